// ### core/async_rx_clock_data_recovery.sv
// Oversampling receive front end with APB registers and interrupt.
// Assumes an APB master on pclk and an asynchronous serial line in.
//
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`include "rx_cdr_regs.svh"
module async_rx_clock_data_recovery
    import rx_cdr_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Serial line
    input  wire logic        serial_rx_line,
    // Interrupt
    output logic             irq
);
    // Registers
    logic [31:0]      ctrl_reg;
    logic [DIV_W-1:0] div_reg;
    logic [2:0]       irq_stat_reg;
    logic [2:0]       irq_en_reg;
    // Line synchroniser and history
    logic             sync1_reg;
    logic             sync2_reg;
    logic             prev_reg;
    // Receive machine
    rx_state_e        state_reg;
    logic [4:0]       samp_reg;
    logic [3:0]       bit_reg;
    logic [1:0]       votes_reg;
    frame_word_t      shift_reg;
    logic             frame_ev;
    logic             ferr_ev;
    logic             noise_ev;
    logic             tick;
    logic [11:0]      head;
    logic             buf_empty;
    logic             buf_full;

    // Control decode
    wire        receiver_on         = ctrl_reg[`CTRL_ON_BIT];
    wire        double_speed_select = ctrl_reg[`CTRL_DS_BIT];
    wire        parity_on           = ctrl_reg[`CTRL_PAR_BIT];
    wire [3:0]  char_len            = ctrl_reg[`CTRL_LEN_LSB +: 4];
    wire [4:0]  spb       = double_speed_select ? `SAMPLES_DOUBLE : `SAMPLES_NORMAL;
    wire [4:0]  vote_lo   = double_speed_select ? `VOTE_FIRST_DOUBLE : `VOTE_FIRST_NORMAL;
    wire [4:0]  vote_hi   = vote_lo + 5'd2;
    wire [3:0]  len_clip  = (char_len < 4'd5) ? 4'd5 : ((char_len > 4'd9) ? 4'd9 : char_len);
    wire [3:0]  data_bits = len_clip + {3'b000, parity_on}; // D = 5 to 10
    wire        in_vote   = (samp_reg >= vote_lo) && (samp_reg <= vote_hi);
    wire        line      = sync2_reg;
    wire        fall      = prev_reg && !line;
    wire        major     = (votes_reg + {1'b0, line}) >= 2'd2;
    wire        vote_done = tick && (samp_reg == vote_hi);
    wire        bit_end   = tick && (samp_reg == spb);
    wire [DIV_W-1:0] baud_divisor = div_reg;

    // APB decode
    wire        acc      = psel && penable;
    wire        wr       = acc && pwrite;
    wire        rd       = acc && !pwrite;
    wire        hit_ctrl = (paddr == `RX_CTRL_OFF);
    wire        hit_div  = (paddr == `RX_DIV_OFF);
    wire        hit_data = (paddr == `RX_DATA_OFF);
    wire        hit_stat = (paddr == `RX_STAT_OFF);
    wire        hit_ist  = (paddr == `RX_IRQ_STAT_OFF);
    wire        hit_ien  = (paddr == `RX_IRQ_EN_OFF);
    wire        hit_iclr = (paddr == `RX_IRQ_CLR_OFF);
    wire        mapped   = hit_ctrl || hit_div || hit_data || hit_stat || hit_ist || hit_ien
                           || hit_iclr;
    wire        pop      = rd && hit_data;
    wire [31:0] rd_mux   = hit_ctrl ? ctrl_reg :
                           hit_div  ? {{(32-DIV_W){1'b0}}, div_reg} :
                           hit_data ? {21'h000000, head[10:0]} :
                           hit_stat ? {29'h0, (state_reg != IDLE), head[11], !buf_empty} :
                           hit_ist  ? {29'h0, irq_stat_reg} :
                           hit_ien  ? {29'h0, irq_en_reg} : 32'h0000_0000;
    wire [2:0]  ev_vec   = {noise_ev, ferr_ev, frame_ev};
    wire [2:0]  clr_vec  = (wr && hit_iclr) ? pwdata[2:0] : 3'b000;

    baud_tick_gen #(.WIDTH(DIV_W)) u_tick (
        .pclk         (pclk),
        .presetn      (presetn),
        .run          (receiver_on),
        .baud_divisor (baud_divisor),
        .tick         (tick)
    );

    rx_frame_buf #(.WIDTH(12), .ALOG(`BUF_DEPTH_LOG2)) u_buf (
        .pclk    (pclk),
        .presetn (presetn),
        .flush   (!receiver_on),
        .wr_en   (frame_ev),
        .wr_data ({ferr_ev, shift_reg}),
        .rd_en   (pop),
        .rd_data (head),
        .empty   (buf_empty),
        .full    (buf_full)
    );

    // Line synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 1'b1;
            sync2_reg <= 1'b1;
        end else begin
            sync1_reg <= serial_rx_line;
            sync2_reg <= sync1_reg;
        end
    end

    // Edge history on sample ticks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg <= 1'b1;
        end else if (tick) begin
            prev_reg <= line;
        end
    end

    // Receive state machine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= IDLE;
            samp_reg  <= 5'd0;
            bit_reg   <= 4'd0;
            votes_reg <= 2'd0;
            shift_reg <= '0;
            frame_ev  <= 1'b0;
            ferr_ev   <= 1'b0;
            noise_ev  <= 1'b0;
        end else begin
            frame_ev <= 1'b0;
            ferr_ev  <= 1'b0;
            noise_ev <= 1'b0;
            if (!receiver_on) begin
                state_reg <= IDLE;
                samp_reg  <= 5'd0;
            end else if (tick) begin
                if (in_vote && state_reg != IDLE) begin
                    votes_reg <= votes_reg + {1'b0, line};
                end
                samp_reg <= samp_reg + 5'd1;
                case (state_reg)
                    IDLE: begin
                        samp_reg  <= 5'd2;
                        votes_reg <= 2'd0;
                        if (fall) begin
                            state_reg <= START;
                        end else begin
                            samp_reg <= 5'd0;
                        end
                    end
                    START: begin
                        if (samp_reg == vote_hi) begin
                            if (major) begin
                                state_reg <= IDLE;
                                noise_ev  <= 1'b1;
                            end
                        end
                        if (samp_reg == spb) begin
                            state_reg <= BITS;
                            samp_reg  <= 5'd1;
                            bit_reg   <= 4'd0;
                            votes_reg <= 2'd0;
                        end
                    end
                    BITS: begin
                        if (vote_done) begin
                            shift_reg <= {major, shift_reg[10:1]};
                        end
                        if (bit_end) begin
                            samp_reg  <= 5'd1;
                            votes_reg <= 2'd0;
                            bit_reg   <= bit_reg + 4'd1;
                            if (bit_reg == data_bits - 4'd1) begin
                                state_reg <= STOP;
                            end
                        end
                    end
                    STOP: begin
                        if (vote_done) begin
                            state_reg <= IDLE;
                            samp_reg  <= 5'd0;
                            frame_ev  <= !buf_full;
                            ferr_ev   <= !major;
                            shift_reg <= shift_reg >> (4'd11 - data_bits);
                        end
                    end
                    default: begin
                        state_reg <= IDLE;
                    end
                endcase
            end
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg   <= `CTRL_RESET;
            div_reg    <= `DIV_RESET;
            irq_en_reg <= 3'b000;
        end else if (wr) begin
            if (hit_ctrl) ctrl_reg <= pwdata & 32'h0000_00f7;
            if (hit_div) div_reg <= pwdata[DIV_W-1:0];
            if (hit_ien) irq_en_reg <= pwdata[2:0];
        end
    end

    // Sticky events, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 3'b000;
            irq          <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~clr_vec) | ev_vec;
            irq          <= |(((irq_stat_reg & ~clr_vec) | ev_vec) & irq_en_reg);
        end
    end

    // APB answer, zero wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end
endmodule

// ### include/rx_cdr_regs.svh
// Offsets, field positions, reset values and counts of the receive front end.
// Assumes inclusion by bare name from the include folder.
`ifndef RX_CDR_REGS_SVH
`define RX_CDR_REGS_SVH
`define RX_CTRL_OFF        12'h000
`define RX_DIV_OFF         12'h004
`define RX_DATA_OFF        12'h008
`define RX_STAT_OFF        12'h00c
`define RX_IRQ_STAT_OFF    12'h010
`define RX_IRQ_EN_OFF      12'h014
`define RX_IRQ_CLR_OFF     12'h018
`define CTRL_ON_BIT        0
`define CTRL_DS_BIT        1
`define CTRL_PAR_BIT       2
`define CTRL_LEN_LSB       4
`define STAT_AVAIL_BIT     0
`define STAT_FERR_BIT      1
`define STAT_BUSY_BIT      2
`define IRQ_FRAME_BIT      0
`define IRQ_FERR_BIT       1
`define IRQ_NOISE_BIT      2
`define CTRL_RESET         32'h0000_0030
`define DIV_RESET          16'h000c
`define SAMPLES_NORMAL     5'd16
`define SAMPLES_DOUBLE     5'd8
`define VOTE_FIRST_NORMAL  5'd8
`define VOTE_FIRST_DOUBLE  5'd4
`define BUF_DEPTH_LOG2     1
`endif

// ### include/rx_cdr_pkg.sv
// Types shared by the receive front end files.
// Assumes nothing beyond a SystemVerilog compiler.
package rx_cdr_pkg;
    typedef enum logic [1:0] {IDLE, START, BITS, STOP} rx_state_e;
    typedef logic [10:0] frame_word_t;
endpackage

// ### core/baud_tick_gen.sv
// Baud divider producing one-cycle oversampling ticks.
// Assumes a divisor held steady by the register file.
`timescale 1ns/1ps
module baud_tick_gen #(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             run,
    input  wire logic [WIDTH-1:0] baud_divisor,
    // Tick out
    output logic                  tick
);
    logic [WIDTH-1:0] count_reg;
    wire              at_end = (count_reg == '0);

    // Count down, reload on zero
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_reg <= '0;
            tick      <= 1'b0;
        end else begin
            count_reg <= (!run || at_end) ? baud_divisor : count_reg - 1'b1;
            tick      <= run && at_end;
        end
    end
endmodule

// ### core/rx_frame_buf.sv
// Small frame memory with registered read data.
// Assumes the writer checks full and the reader checks empty.
`timescale 1ns/1ps
module rx_frame_buf #(
    parameter int WIDTH = 12,
    parameter int ALOG  = 1
) (
    // Clock and reset
    input  wire logic             pclk,
    input  wire logic             presetn,
    // Control
    input  wire logic             flush,
    // Write side
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read side
    input  wire logic             rd_en,
    output logic      [WIDTH-1:0] rd_data,
    output logic                  empty,
    output logic                  full
);
    logic [WIDTH-1:0] mem [2**ALOG];
    logic [ALOG:0]    wp_reg;
    logic [ALOG:0]    rp_reg;
    logic [ALOG:0]    rp_next;
    logic [ALOG:0]    wp_next;
    wire              do_rd = rd_en && !empty;
    wire              do_wr = wr_en && !full;
    // Write into the slot about to be shown bypasses the memory
    wire              fwd   = do_wr && (wp_reg[ALOG-1:0] == rp_next[ALOG-1:0]);
    wire              will_empty = (wp_next == rp_next);

    assign rp_next = do_rd ? rp_reg + 1'b1 : rp_reg;
    assign wp_next = do_wr ? wp_reg + 1'b1 : wp_reg;
    assign empty   = (wp_reg == rp_reg);
    assign full    = (wp_reg[ALOG-1:0] == rp_reg[ALOG-1:0]) && (wp_reg[ALOG] != rp_reg[ALOG]);

    // Storage, no reset needed
    always_ff @(posedge pclk) begin
        if (wr_en && !full) begin
            mem[wp_reg[ALOG-1:0]] <= wr_data;
        end
    end

    // Pointers and registered head word
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            rd_data <= '0;
        end else if (flush) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            rd_data <= '0;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            // Head reads zero when empty, never an unwritten slot
            rd_data <= will_empty ? '0 : (fwd ? wr_data : mem[rp_next[ALOG-1:0]]);
        end
    end
endmodule

// ### test/rx_cdr_checker.sv
// Checker of APB timing, refusals and interrupt masking at the receive front end.
// Assumes binding to the top module and a master that keeps the APB protocol.
`timescale 1ns/1ps
module rx_cdr_checker (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Interrupt
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Completed transfers
    wire logic rd_done = psel && penable && pready && !pwrite;
    wire logic wr_done = psel && penable && pready && pwrite;
    logic      off_reg;
    // Receiver held off since the last control write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) off_reg <= 1'b1;
        else if (wr_done && paddr == 12'h000) off_reg <= !pwdata[0];
    end
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    idle_data_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata nonzero outside access");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    unmapped_err_a: assert property (psel && !penable && paddr > 12'h018 |=> pslverr)
        else $error("unmapped address not refused");
    off_flush_a:
        assert property (off_reg && rd_done && paddr == 12'h00c |-> prdata[2:0] == 3'h0)
        else $error("status not empty with receiver off");
    clr_zero_a: assert property (rd_done && paddr == 12'h018 |-> prdata == 32'h0)
        else $error("clear register read nonzero");
    ctrl_gap_a: assert property (rd_done && paddr == 12'h000 |-> !prdata[3])
        else $error("control bit three read nonzero");
    irq_mask_a: assert property (wr_done && paddr == 12'h014 && pwdata[2:0] == 3'h0 |=> ##1 !irq)
        else $error("irq high with all sources masked");
endmodule

bind async_rx_clock_data_recovery rx_cdr_checker checker_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));

// ### test/serial_tx_model.sv
// Remote serial transmitter on the receive line, idle high.
// Assumes the bench calls its tasks right after a pclk edge; times in pclk cycles.
`timescale 1ns/1ps
module serial_tx_model (
    // Clock
    input wire logic pclk,
    // Serial line
    output logic     line
);
    initial line = 1'b1;
    // Drive a level for n cycles
    task automatic hold(input logic v, input int n);
        line <= v;
        repeat (n) @(posedge pclk);
    endtask
    // Eight bits LSB first; s samples per bit, c cycles per sample
    task automatic send(input logic [7:0] d, input int s, input int c,
                        input logic stop, input int stop_s, input logic glitch);
        hold(1'b0, s * c);
        for (int i = 0; i < 8; i++) begin
            hold(d[i], (s / 2) * c);
            hold(d[i] ^ glitch, c);        // One-sample spike at bit centre
            hold(d[i], (s / 2 - 1) * c);
        end
        hold(stop, stop_s * c);            // Stop bit, possibly cut short
        line <= 1'b1;
    endtask
endmodule

// ### test/testbench.sv
// Self-checking bench: APB master, serial stimulus through the transmitter model.
// Assumes the checker is bound to the design and the register header is reachable.
`timescale 1ns/1ps
`include "rx_cdr_regs.svh"
module testbench;
    localparam int C = 4;  // Cycles per sample with divisor 3
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, irq, serial_rx_line;
    int          miscompares = 0, total_checks = 0;
    // Clock
    always #20 pclk = ~pclk;
    // Design and far-side transmitter
    async_rx_clock_data_recovery dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_rx_line(serial_rx_line), .irq(irq));
    serial_tx_model tx (.pclk(pclk), .line(serial_rx_line));
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask
    // One APB transfer, bounded wait for pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            chk("pready", 32'h1, 32'h0);
            end_of_test();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] x,
                      input logic [31:0] m = 32'hffff_ffff);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(nm, x, r & m);
    endtask
    // Poll status until a frame is stored
    task automatic wait_frame();
        logic [31:0] r;
        logic        e;
        for (int i = 0; i < 50; i++) begin
            apb(1'b0, `RX_STAT_OFF, 32'h0, r, e);
            if (r[0] === 1'b1) return;
        end
        chk("frame available", 32'h1, 32'h0);
        end_of_test();
    endtask
    // Reset values, write-only and unmapped places
    task automatic t_reset();
        logic [31:0] r;
        logic        e;
        rd("ctrl", `RX_CTRL_OFF, `CTRL_RESET);
        rd("divisor", `RX_DIV_OFF, {16'h0, `DIV_RESET});
        rd("status", `RX_STAT_OFF, 32'h0);
        rd("irq clear", `RX_IRQ_CLR_OFF, 32'h0);
        apb(1'b0, 12'h020, 32'h0, r, e);
        chk("unmapped error", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
    endtask
    // Frame with centre spikes; interrupt raised, masked, cleared
    task automatic t_frame();
        wr(`RX_IRQ_EN_OFF, 32'h1);
        tx.send(8'ha5, 16, C, 1'b1, 16, 1'b1);
        wait_frame();
        rd("frame error", `RX_STAT_OFF, 32'h0, 32'h2);
        chk("irq raised", 32'h1, {31'h0, irq});
        wr(`RX_IRQ_EN_OFF, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(`RX_IRQ_EN_OFF, 32'h1);
        wr(`RX_IRQ_CLR_OFF, 32'h1);
        repeat (2) @(posedge pclk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        rd("data", `RX_DATA_OFF, 32'ha5, 32'hff);
    endtask
    // Short low pulse rejected as noise
    task automatic t_noise();
        tx.hold(1'b0, 3 * C);
        tx.hold(1'b1, 40 * C);
        rd("noise stored", `RX_STAT_OFF, 32'h0, 32'h1);
        rd("noise event", `RX_IRQ_STAT_OFF, 32'h4, 32'h4);
        wr(`RX_IRQ_CLR_OFF, 32'h7);
    endtask
    // Low stop bit, error kept with its own frame
    task automatic t_ferr();
        tx.send(8'h3c, 16, C, 1'b0, 16, 1'b0);
        tx.hold(1'b1, 16 * C);
        tx.send(8'hc3, 16, C, 1'b1, 16, 1'b0);
        wait_frame();
        rd("head error", `RX_STAT_OFF, 32'h3, 32'h3);
        rd("data one", `RX_DATA_OFF, 32'h3c, 32'hff);
        rd("next error", `RX_STAT_OFF, 32'h1, 32'h3);
        rd("data two", `RX_DATA_OFF, 32'hc3, 32'hff);
        rd("ferr event", `RX_IRQ_STAT_OFF, 32'h2, 32'h2);
        wr(`RX_IRQ_CLR_OFF, 32'h7);
    endtask
    // Next start right after the stop vote
    task automatic t_b2b();
        tx.send(8'h5a, 16, C, 1'b1, 12, 1'b0);
        tx.send(8'h96, 16, C, 1'b1, 12, 1'b0);
        wait_frame();
        rd("early one", `RX_DATA_OFF, 32'h5a, 32'hff);
        rd("early two", `RX_DATA_OFF, 32'h96, 32'hff);
    endtask
    // Eight samples per bit
    task automatic t_double();
        wr(`RX_CTRL_OFF, 32'h83);
        tx.send(8'h69, 8, C, 1'b1, 8, 1'b1);
        wait_frame();
        rd("double data", `RX_DATA_OFF, 32'h69, 32'hff);
        wr(`RX_CTRL_OFF, 32'h81);
    endtask
    // Short character length and parity bit counted in the frame
    task automatic t_len();
        wr(`RX_CTRL_OFF, 32'h51);
        tx.send(8'hf3, 16, C, 1'b1, 16, 1'b0);
        wait_frame();
        rd("five bit error", `RX_STAT_OFF, 32'h0, 32'h2);
        rd("five bit data", `RX_DATA_OFF, 32'h13, 32'h7ff);
        wr(`RX_CTRL_OFF, 32'h75);
        tx.send(8'h4b, 16, C, 1'b1, 16, 1'b0);
        wait_frame();
        rd("parity data", `RX_DATA_OFF, 32'h4b, 32'h7ff);
        wr(`RX_CTRL_OFF, 32'h81);
    endtask
    // Receiver off mid-frame flushes and aborts
    task automatic t_flush();
        tx.send(8'h11, 16, C, 1'b1, 16, 1'b0);
        wait_frame();
        fork
            tx.send(8'h22, 16, C, 1'b1, 16, 1'b0);
            begin
                repeat (200) @(posedge pclk);
                wr(`RX_CTRL_OFF, 32'h80);
            end
        join
        rd("off status", `RX_STAT_OFF, 32'h0);
        wr(`RX_CTRL_OFF, 32'h81);
        rd("on status", `RX_STAT_OFF, 32'h0, 32'h1);
    endtask
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        wr(`RX_DIV_OFF, 32'h3);
        wr(`RX_CTRL_OFF, 32'h81);
        t_frame();
        t_noise();
        t_ferr();
        t_b2b();
        t_double();
        t_len();
        t_flush();
        end_of_test();
    end
    // Watchdog
    initial begin
        repeat (100000) @(posedge pclk);
        chk("watchdog", 32'h0, 32'h1);
        end_of_test();
    end
endmodule
